// ==== core/span_pkg.sv ====
// Purpose: Shared constants and types for the channel input span register bank.
// Assumes: Byte-wide registers, each on one aligned 32-bit APB word.
// Notes:   Register indices are multiplied by four to form byte addresses.
package span_pkg;

    localparam int        DATA_W        = 32;
    localparam int        REG_W         = 8;
    localparam int        CODE_W        = 4;
    localparam int        MV_W          = 16;
    localparam int        PAIR_COUNT    = 3;
    localparam int        CHAN_COUNT    = 6;
    localparam int        HI_LSB        = 4;
    localparam int        WORD_SHIFT    = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PAIR_B   = 8'h04;
    localparam logic [7:0] IDX_PAIR_C   = 8'h05;
    localparam logic [7:0] IDX_PAIR_D   = 8'h06;
    localparam logic [7:0] PAIR_RESET   = 8'h33;
    localparam logic [3:0] CODE_RESET   = 4'h3;

    // Span code boundaries.
    localparam logic [3:0] CODE_BI_2V5  = 4'h0;
    localparam logic [3:0] CODE_BI_5V   = 4'h1;
    localparam logic [3:0] CODE_BI_6V25 = 4'h2;
    localparam logic [3:0] CODE_BI_10V  = 4'h3;
    localparam logic [3:0] CODE_BI_12V5 = 4'h4;
    localparam logic [3:0] CODE_UNI_5V  = 4'h5;
    localparam logic [3:0] CODE_UNI_10V = 4'h6;
    localparam logic [3:0] CODE_UNI_12V5 = 4'h7;
    localparam logic [3:0] CODE_DI_5V   = 4'h8;
    localparam logic [3:0] CODE_DI_10V  = 4'h9;
    localparam logic [3:0] CODE_DI_12V5 = 4'ha;
    localparam logic [3:0] CODE_DI_20V  = 4'hb;

    // Full-scale magnitudes in millivolts.
    localparam logic [15:0] MV_2500     = 16'h09c4;
    localparam logic [15:0] MV_5000     = 16'h1388;
    localparam logic [15:0] MV_6250     = 16'h186a;
    localparam logic [15:0] MV_10000    = 16'h2710;
    localparam logic [15:0] MV_12500    = 16'h30d4;
    localparam logic [15:0] MV_20000    = 16'h4e20;
    localparam logic [15:0] MV_NONE     = 16'h0000;

    typedef enum logic [1:0] {
        KIND_BIPOLAR,
        KIND_UNIPOLAR,
        KIND_DIFFERENTIAL,
        KIND_UNDEFINED
    } span_kind_type;

endpackage

// ==== core/span_decoder.sv ====
// Purpose: Turns one channel's 4-bit span code into a registered span kind and full scale.
// Assumes: Code comes from a register on the same clock.
// Notes:   Outputs lag the code by one clock edge.
`timescale 1ns/1ns
module span_decoder
    import span_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [CODE_W-1:0] code,
    output span_kind_type          kind,
    output logic      [MV_W-1:0]   full_mv
);

    span_kind_type        next_kind;
    logic     [MV_W-1:0]  next_mv;

    always_comb begin
        next_kind = KIND_UNDEFINED;
        next_mv   = MV_NONE;
        case (code)
            CODE_BI_2V5:   begin next_kind = KIND_BIPOLAR;      next_mv = MV_2500;  end
            CODE_BI_5V:    begin next_kind = KIND_BIPOLAR;      next_mv = MV_5000;  end
            CODE_BI_6V25:  begin next_kind = KIND_BIPOLAR;      next_mv = MV_6250;  end
            CODE_BI_10V:   begin next_kind = KIND_BIPOLAR;      next_mv = MV_10000; end
            CODE_BI_12V5:  begin next_kind = KIND_BIPOLAR;      next_mv = MV_12500; end
            CODE_UNI_5V:   begin next_kind = KIND_UNIPOLAR;     next_mv = MV_5000;  end
            CODE_UNI_10V:  begin next_kind = KIND_UNIPOLAR;     next_mv = MV_10000; end
            CODE_UNI_12V5: begin next_kind = KIND_UNIPOLAR;     next_mv = MV_12500; end
            CODE_DI_5V:    begin next_kind = KIND_DIFFERENTIAL; next_mv = MV_5000;  end
            CODE_DI_10V:   begin next_kind = KIND_DIFFERENTIAL; next_mv = MV_10000; end
            CODE_DI_12V5:  begin next_kind = KIND_DIFFERENTIAL; next_mv = MV_12500; end
            CODE_DI_20V:   begin next_kind = KIND_DIFFERENTIAL; next_mv = MV_20000; end
            // Undefined codes are flagged, never guessed.
            default:       begin next_kind = KIND_UNDEFINED;    next_mv = MV_NONE;  end
        endcase
    end

    // Reset matches the register reset code so the channel never sees a false span.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            kind    <= KIND_BIPOLAR;
            full_mv <= MV_10000;
        end else begin
            kind    <= next_kind;
            full_mv <= next_mv;
        end
    end

    a_bipolar_order: assert property (@(posedge clk) disable iff (sys_rst)
        (code == CODE_BI_2V5 |=> kind == KIND_BIPOLAR && full_mv == MV_2500)
        and (code == CODE_BI_12V5 |=> kind == KIND_BIPOLAR && full_mv == MV_12500))
        else $error("Bipolar span order wrong.");
    a_unipolar_span: assert property (@(posedge clk) disable iff (sys_rst)
        code inside {[CODE_UNI_5V:CODE_UNI_12V5]} |=> kind == KIND_UNIPOLAR && full_mv >= MV_5000)
        else $error("Unipolar code not decoded as unipolar.");
    a_diff_span_top: assert property (@(posedge clk) disable iff (sys_rst)
        code inside {[CODE_DI_5V:CODE_DI_20V]} |=> kind == KIND_DIFFERENTIAL
            && (full_mv == MV_20000) == ($past(code) == CODE_DI_20V))
        else $error("Differential span decode wrong.");

endmodule

// ==== core/channel_input_range_regs.sv ====
// Purpose: APB register bank holding span codes for channels three to eight, with decoded spans.
// Assumes: Single clock, APB master on the same clock, zero wait states.
// Notes:   Unmapped or misaligned addresses answer with pslverr and read as zero.
`timescale 1ns/1ns
module channel_input_range_regs
    import span_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [DATA_W-1:0]            pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [DATA_W-1:0]            prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [CODE_W-1:0]            third_channel_span_code,
    output logic      [CODE_W-1:0]            fourth_channel_span_code,
    output logic      [CODE_W-1:0]            fifth_channel_span_code,
    output logic      [CODE_W-1:0]            sixth_channel_span_code,
    output logic      [CODE_W-1:0]            seventh_channel_span_code,
    output logic      [CODE_W-1:0]            eighth_channel_span_code,
    output span_kind_type [CHAN_COUNT-1:0]    span_kind,
    output logic      [CHAN_COUNT-1:0][MV_W-1:0] span_full_mv
);

    // The highest byte address must fit in the address bus.
    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W too small to reach the span registers.");
    end

    // Slot number of a byte address; PAIR_COUNT means no register there.
    function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        idx = addr >> WORD_SHIFT;
        if (addr[1:0] != 2'h0) begin
            slot_of = 2'(PAIR_COUNT);
        end else if (idx == ADDR_W'(IDX_PAIR_B)) begin
            slot_of = 2'h0;
        end else if (idx == ADDR_W'(IDX_PAIR_C)) begin
            slot_of = 2'h1;
        end else if (idx == ADDR_W'(IDX_PAIR_D)) begin
            slot_of = 2'h2;
        end else begin
            slot_of = 2'(PAIR_COUNT);
        end
    endfunction

    logic [REG_W-1:0] pair_reg [PAIR_COUNT];

    wire       setup_phase  = psel && !penable;
    wire       access_phase = psel && penable;
    wire [1:0] hit_slot     = slot_of(paddr);
    wire       hit_valid    = hit_slot != 2'(PAIR_COUNT);
    // Only byte lane 0 carries register data; other lanes are ignored.
    wire       write_take   = access_phase && pwrite && hit_valid && pstrb[0];
    wire [REG_W-1:0] read_byte = hit_valid ? pair_reg[hit_slot] : '0;

    // No wait states, so the access phase always completes in one cycle.
    assign pready = 1'b1;

    // Read data and error are captured at the setup edge, ready for the access phase.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= (!pwrite) ? {{(DATA_W-REG_W){1'b0}}, read_byte} : '0;
            pslverr <= !hit_valid;
        end
    end

    for (genvar s = 0; s < PAIR_COUNT; s++) begin : g_pair
        // Reset to 0x33, write on the access edge.
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                pair_reg[s] <= PAIR_RESET;
            end else if (write_take && hit_slot == 2'(s)) begin
                pair_reg[s] <= pwdata[REG_W-1:0];
            end
        end
    end

    // Channel three low nibble, channel four high.
    assign third_channel_span_code   = pair_reg[0][HI_LSB-1:0];
    assign fourth_channel_span_code  = pair_reg[0][REG_W-1:HI_LSB];
    // Channel five low nibble, channel six high.
    assign fifth_channel_span_code   = pair_reg[1][HI_LSB-1:0];
    assign sixth_channel_span_code   = pair_reg[1][REG_W-1:HI_LSB];
    // Channel seven low nibble, channel eight high.
    assign seventh_channel_span_code = pair_reg[2][HI_LSB-1:0];
    assign eighth_channel_span_code  = pair_reg[2][REG_W-1:HI_LSB];

    wire [CODE_W-1:0] chan_code [CHAN_COUNT];
    assign chan_code[0] = third_channel_span_code;
    assign chan_code[1] = fourth_channel_span_code;
    assign chan_code[2] = fifth_channel_span_code;
    assign chan_code[3] = sixth_channel_span_code;
    assign chan_code[4] = seventh_channel_span_code;
    assign chan_code[5] = eighth_channel_span_code;

    for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_decode
        // Each channel decodes its own field.
        span_decoder u_decoder (
            .clk     (clk),
            .sys_rst (sys_rst),
            .code    (chan_code[c]),
            .kind    (span_kind[c]),
            .full_mv (span_full_mv[c])
        );
    end

    a_write_pair_c: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && paddr == ADDR_W'(IDX_PAIR_C) << WORD_SHIFT
        |=> sixth_channel_span_code == $past(pwdata[7:4]) && fifth_channel_span_code == $past(pwdata[3:0]))
        else $error("Pair C write not stored in its nibbles.");
    a_write_pair_d: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && paddr == ADDR_W'(IDX_PAIR_D) << WORD_SHIFT
        |=> eighth_channel_span_code == $past(pwdata[7:4]) && seventh_channel_span_code == $past(pwdata[3:0]))
        else $error("Pair D write not stored in its nibbles.");
    a_write_pair_b: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && paddr == ADDR_W'(IDX_PAIR_B) << WORD_SHIFT
        |=> fourth_channel_span_code == $past(pwdata[7:4]) && third_channel_span_code == $past(pwdata[3:0]))
        else $error("Pair B write not stored in its nibbles.");
    a_reset_codes: assert property (@(posedge clk)
        $fell(sys_rst) |-> pair_reg[0] == PAIR_RESET && pair_reg[1] == PAIR_RESET && pair_reg[2] == PAIR_RESET
            && span_kind[0] == KIND_BIPOLAR && span_full_mv[5] == MV_10000)
        else $error("Span registers not at reset value after reset.");
    a_read_back: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && !pwrite && paddr == ADDR_W'(IDX_PAIR_C) << WORD_SHIFT
        |=> prdata == {24'h000000, sixth_channel_span_code, fifth_channel_span_code} && !pslverr)
        else $error("Read of pair C returned wrong data.");
    a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && !hit_valid |=> pslverr && prdata == '0 && $stable(pair_reg[2]) ##1 $stable(pair_reg[2]))
        else $error("Unmapped access not refused.");
    a_decode_follow: assert property (@(posedge clk) disable iff (sys_rst)
        $past(write_take) && $past(hit_slot) == 2'h0 && $past(pwdata[3:0]) == CODE_BI_2V5
        |=> span_kind[0] == KIND_BIPOLAR && span_full_mv[0] == MV_2500)
        else $error("Channel three span not decoded two edges after write.");
    a_undef_flag: assert property (@(posedge clk) disable iff (sys_rst)
        eighth_channel_span_code > CODE_DI_20V |=> span_kind[5] == KIND_UNDEFINED && span_full_mv[5] == MV_NONE)
        else $error("Undefined code not flagged.");

    a_ready_high: assert property (@(posedge clk) disable iff (sys_rst)
        access_phase |-> pready)
        else $error("Access phase not answered at once.");
    a_read_pair_b: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && !pwrite && paddr == ADDR_W'(IDX_PAIR_B) << WORD_SHIFT
        |=> prdata == {24'h000000, fourth_channel_span_code, third_channel_span_code} && !pslverr)
        else $error("Read of pair B returned wrong data.");
    a_read_pair_d: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && !pwrite && paddr == ADDR_W'(IDX_PAIR_D) << WORD_SHIFT
        |=> prdata == {24'h000000, eighth_channel_span_code, seventh_channel_span_code} && !pslverr)
        else $error("Read of pair D returned wrong data.");
    a_strobe_guard: assert property (@(posedge clk) disable iff (sys_rst)
        access_phase && pwrite && !pstrb[0]
        |=> $stable(pair_reg[0]) && $stable(pair_reg[1]) && $stable(pair_reg[2]))
        else $error("Write without strobe changed a register.");
    a_hold_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        !write_take |=> $stable(pair_reg[0]) && $stable(pair_reg[1]) && $stable(pair_reg[2]))
        else $error("Register changed without a write.");
    a_write_only_c: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && hit_slot == 2'h1 |=> $stable(pair_reg[0]) && $stable(pair_reg[2]))
        else $error("Pair C write disturbed another register.");
    a_write_only_d: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && hit_slot == 2'h2 |=> $stable(pair_reg[0]) && $stable(pair_reg[1]))
        else $error("Pair D write disturbed another register.");
    a_write_only_b: assert property (@(posedge clk) disable iff (sys_rst)
        write_take && hit_slot == 2'h0 |=> $stable(pair_reg[1]) && $stable(pair_reg[2]))
        else $error("Pair B write disturbed another register.");

    a_write_rdata_zero: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && pwrite |=> prdata == '0)
        else $error("Write returned nonzero read data.");
    a_mapped_okay: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && hit_valid |=> !pslverr)
        else $error("Mapped access answered with an error.");
    a_err_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
        setup_phase && !pwrite && !hit_valid |=> prdata == '0 && pslverr)
        else $error("Unmapped read returned data.");
    a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
        prdata[DATA_W-1:REG_W] == '0)
        else $error("Read data upper bytes not zero.");
    a_answer_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !setup_phase |=> $stable(prdata) && $stable(pslverr))
        else $error("Read answer changed outside a setup cycle.");
    a_code_reset: assert property (@(posedge clk)
        $fell(sys_rst) |-> third_channel_span_code == CODE_RESET && eighth_channel_span_code == CODE_RESET)
        else $error("Span code not at reset value after reset.");

    a_kind_scale_pair: assert property (@(posedge clk) disable iff (sys_rst)
        (span_kind[0] == KIND_UNDEFINED) == (span_full_mv[0] == MV_NONE))
        else $error("Span kind and full scale disagree.");
    a_decode_ch4_bi: assert property (@(posedge clk) disable iff (sys_rst)
        fourth_channel_span_code == CODE_BI_6V25 |=> span_kind[1] == KIND_BIPOLAR && span_full_mv[1] == MV_6250)
        else $error("Channel four bipolar span wrong.");
    a_decode_ch6_uni: assert property (@(posedge clk) disable iff (sys_rst)
        sixth_channel_span_code == CODE_UNI_12V5 |=> span_kind[3] == KIND_UNIPOLAR && span_full_mv[3] == MV_12500)
        else $error("Channel six unipolar span wrong.");
    a_decode_ch8_di: assert property (@(posedge clk) disable iff (sys_rst)
        eighth_channel_span_code == CODE_DI_20V |=> span_kind[5] == KIND_DIFFERENTIAL && span_full_mv[5] == MV_20000)
        else $error("Channel eight differential span wrong.");
    a_decode_ch7_uni: assert property (@(posedge clk) disable iff (sys_rst)
        seventh_channel_span_code == CODE_UNI_5V |=> span_kind[4] == KIND_UNIPOLAR && span_full_mv[4] == MV_5000)
        else $error("Channel seven unipolar span wrong.");

    c_write_c: cover property (@(posedge clk) write_take && hit_slot == 2'h1);
    c_read_d: cover property (@(posedge clk) setup_phase && !pwrite && hit_slot == 2'h2 ##1 access_phase);
    c_unmapped: cover property (@(posedge clk) access_phase && pslverr);
    c_diff_span: cover property (@(posedge clk) span_kind[2] == KIND_DIFFERENTIAL);
    c_uni_span: cover property (@(posedge clk) span_kind[3] == KIND_UNIPOLAR);

endmodule

// ==== verification/apb_host_model.sv ====
// Purpose: APB host that configures the span register bank.
// Assumes: Slave answers on its own; the host counts no fixed wait.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ns
module apb_host_model
    import span_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [7:0]             paddr,
    output logic [DATA_W-1:0]      pwdata,
    output logic [3:0]             pstrb
);
    logic timed_out;

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, timed_out} = '0;
    end

    // Legal codes only.
    // Callers keep span codes below twelve, since higher codes select no span.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [DATA_W-1:0] d,
                        input logic [3:0] s, output logic [DATA_W-1:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        timed_out = (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// ==== verification/channel_input_range_regs_test.sv ====
// Purpose: Self-checking bench for the span register bank.
// Assumes: Host model drives APB; byte address is four times the index.
// Notes:   Expected spans come from a local table, never from the design.
`timescale 1ns/1ns
module channel_input_range_regs_test
    import span_pkg::*;
;
    localparam logic [MV_W-1:0] MV_TAB [12] = '{MV_2500, MV_5000, MV_6250, MV_10000, MV_12500, MV_5000,
                                               MV_10000, MV_12500, MV_5000, MV_10000, MV_12500, MV_20000};
    logic                              clk;
    logic                              sys_rst;
    logic                              psel;
    logic                              penable;
    logic                              pwrite;
    logic                              pready;
    logic                              pslverr;
    logic                              err;
    logic [7:0]                        paddr;
    logic [3:0]                        pstrb;
    logic [DATA_W-1:0]                 pwdata;
    logic [DATA_W-1:0]                 prdata;
    logic [DATA_W-1:0]                 rd;
    logic [CHAN_COUNT-1:0][CODE_W-1:0] codes;
    span_kind_type [CHAN_COUNT-1:0]    span_kind;
    logic [CHAN_COUNT-1:0][MV_W-1:0]   span_full_mv;
    int                                error_cnt;
    int                                num_checks;

    channel_input_range_regs dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .third_channel_span_code(codes[0]), .fourth_channel_span_code(codes[1]),
        .fifth_channel_span_code(codes[2]), .sixth_channel_span_code(codes[3]),
        .seventh_channel_span_code(codes[4]), .eighth_channel_span_code(codes[5]),
        .span_kind(span_kind), .span_full_mv(span_full_mv));

    apb_host_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic span_kind_type kind_of(input logic [3:0] c);
        return (c <= CODE_BI_12V5) ? KIND_BIPOLAR : (c <= CODE_UNI_12V5) ? KIND_UNIPOLAR : KIND_DIFFERENTIAL;
    endfunction

    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s);
        host.xfer(wr, a, d, s, rd, err);
        if (host.timed_out) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
        access(1'b0, a, 32'h0, 4'h0);
        check_word(rd, {24'h0, exp});
        check_word({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic check_span(input int ch, input logic [3:0] c);
        check_word({28'h0, codes[ch]}, {28'h0, c});
        check_word({30'h0, span_kind[ch]}, {30'h0, kind_of(c)});
        check_word({16'h0, span_full_mv[ch]}, {16'h0, MV_TAB[c]});
    endtask

    initial begin
        error_cnt = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int r = 0; r < 3; r++) read_check(8'h10 + 8'(4 * r), PAIR_RESET, 1'b0);
        for (int i = 0; i < 6; i++) check_span(i, CODE_RESET);
        for (int c = 0; c < 12; c++) begin
            for (int r = 0; r < 3; r++) access(1'b1, 8'h10 + 8'(4 * r), {24'h0, 4'(c), 4'(11 - c)}, 4'h1);
            repeat (2) @(posedge clk);
            for (int i = 0; i < 6; i++) check_span(i, i[0] ? 4'(c) : 4'(11 - c));
            for (int r = 0; r < 3; r++) read_check(8'h10 + 8'(4 * r), {4'(c), 4'(11 - c)}, 1'b0);
        end
        // Strobe-less and misaligned writes must leave the registers alone.
        access(1'b1, 8'h18, 32'h0000_0012, 4'h0);
        check_word({31'h0, err}, 32'h0);
        access(1'b1, 8'h15, 32'h0000_0044, 4'h1);
        check_word({31'h0, err}, 32'h1);
        read_check(8'h18, 8'hb0, 1'b0);
        read_check(8'h14, 8'hb0, 1'b0);
        read_check(8'h1c, 8'h00, 1'b1);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        read_check(8'h10, PAIR_RESET, 1'b0);
        summarize();
    end
endmodule
